// ===== bench/qcr_count_model.sv
// Purpose: up/down counter source for the read-out block
// Assumes: step and dir change just after rising edges
// Notes: value moves one edge after count_event
`timescale 1ns/1ps

module qcr_count_model #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // stimulus
  input wire logic step,
  input wire logic dir,
  // to the block
  output logic [WIDTH-1:0] counter_value,
  output logic count_event,
  output logic count_up
);
  logic pend_reg;
  logic dir_reg;
  assign count_event = step;
  assign count_up = dir;
  // keeps counting whatever the reader does
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend_reg <= 1'b0;
      dir_reg <= 1'b0;
      counter_value <= '0;
    end else begin
      pend_reg <= step;
      dir_reg <= dir;
      if (pend_reg) begin
        counter_value <= dir_reg ? counter_value + 1'b1 : counter_value - 1'b1;
      end
    end
  end
endmodule : qcr_count_model

// ===== bench/tb_top.sv
// Purpose: self-checking bench for the read-out block
// Assumes: 100 MHz clock, inputs moved at rising edges
// Notes: expected position tracked locally in pos
`timescale 1ns/1ps

module tb_top;
  logic clock = 0, rstn = 0, clear_n = 1, step = 0, dir = 0, oe_n = 1, byte_sel = 1;
  logic [15:0] counter_value, pos = 0, snap;
  logic count_event, count_up, byte_bus_oe, dcp, cbp, up_down, inhibit;
  logic [7:0] byte_bus, nbus;
  logic [15:0] ext_cnt = 16'h0000, ext_snap;
  wire [7:0] bus_w = byte_bus_oe ? byte_bus : 8'hzz;
  int failures = 0, checks = 0;

  qcr_count_model cmodel (.clock(clock), .rstn(rstn), .step(step), .dir(dir),
    .counter_value(counter_value), .count_event(count_event), .count_up(count_up));
  qcr_readout uut (.clock(clock), .rstn(rstn), .clear_n(clear_n),
    .counter_value(counter_value), .count_event(count_event), .count_up(count_up),
    .oe_n(oe_n), .byte_sel(byte_sel), .byte_bus(byte_bus), .byte_bus_oe(byte_bus_oe),
    .decode_count_pulse(dcp), .carry_borrow_pulse(cbp), .up_down(up_down),
    .inhibit(inhibit));
  qcr_readout #(.WIDTH(12)) uut_narrow (.clock(clock), .rstn(rstn), .clear_n(clear_n),
    .counter_value(counter_value[11:0]), .count_event(count_event), .count_up(count_up),
    .oe_n(oe_n), .byte_sel(byte_sel), .byte_bus(nbus), .byte_bus_oe(),
    .decode_count_pulse(), .carry_borrow_pulse(), .up_down(), .inhibit());

  // external cascade counter fed by the carry pulse
  always @(posedge cbp) ext_cnt <= up_down ? ext_cnt + 16'h0001 : ext_cnt - 16'h0001;

  initial forever #5 clock = ~clock;

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks++;
    if (e !== g) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic cnt(logic d, logic wrap);
    @(posedge clock) step <= 1;
    dir <= d;
    @(posedge clock) step <= 0;
    #1 chk("dir_lead", d, up_down);
    @(posedge clock) #1 chk("dec_hi", 1, dcp);
    chk("cas", wrap, cbp);
    chk("dir_hold", d, up_down);
    @(negedge clock) #1 chk("dec_lo", 0, dcp);
    chk("cas_lo", 0, cbp);
    pos = d ? pos + 1 : pos - 1;
  endtask : cnt

  task automatic rd_low();
    @(posedge clock) oe_n <= 0;
    byte_sel <= 1;
    repeat (2) @(negedge clock);
    #1 chk("low", {8'h00, pos[7:0]}, {8'h00, bus_w});
    chk("no_inh", 0, inhibit);
    @(posedge clock) oe_n <= 1;
    #1 chk("float", 0, byte_bus_oe);
  endtask : rd_low

  task automatic t_count();
    cnt(0, 1);
    cnt(1, 1);
    cnt(1, 0);
    repeat (2) @(posedge clock);
    rd_low();
    $display("done counting");
  endtask : t_count

  task automatic t_two();
    @(posedge clock) oe_n <= 0;
    byte_sel <= 0;
    @(negedge clock) #1 chk("inh_set", 1, inhibit);
    snap = pos;
    ext_snap = ext_cnt;
    chk("ext_snap", 16'h0000, ext_snap);
    chk("high", {8'h00, snap[15:8]}, {8'h00, bus_w});
    cnt(0, 0);
    cnt(0, 1);
    chk("frozen", {8'h00, snap[15:8]}, {8'h00, bus_w});
    chk("ext_live", 16'hffff, ext_cnt);
    @(posedge clock) byte_sel <= 1;
    @(negedge clock) #1 chk("low_frz", {8'h00, snap[7:0]}, {8'h00, bus_w});
    chk("inh_keep", 1, inhibit);
    @(posedge clock) oe_n <= 1;
    @(negedge clock) #1 chk("inh_clr", 0, inhibit);
    rd_low();
    $display("done two byte read");
  endtask : t_two

  task automatic t_pulse();
    @(posedge clock) oe_n <= 0;
    byte_sel <= 0;
    @(negedge clock) #1 chk("p_set", 1, inhibit);
    @(posedge clock) oe_n <= 1;
    @(negedge clock) #1 chk("p_gap", 1, inhibit);
    chk("p_float", 0, byte_bus_oe);
    @(posedge clock) oe_n <= 0;
    byte_sel <= 1;
    @(negedge clock) #1 chk("p_arm", 1, inhibit);
    chk("p_low", {8'h00, pos[7:0]}, {8'h00, bus_w});
    @(posedge clock) oe_n <= 1;
    @(negedge clock) #1 chk("p_clr", 0, inhibit);
    $display("done two pulse read");
  endtask : t_pulse

  task automatic t_clear();
    @(posedge clock) oe_n <= 0;
    byte_sel <= 0;
    @(negedge clock) #1 chk("inh_set", 1, inhibit);
    chk("narrow_hi", 16'h000f, {8'h00, nbus});
    @(posedge clock) clear_n <= 0;
    #1 chk("clr_inh", 0, inhibit);
    chk("clr_lat", 0, {8'h00, bus_w});
    @(posedge clock) clear_n <= 1;
    oe_n <= 1;
    rd_low();
    $display("done clear");
  endtask : t_clear

  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    #100000;
    failures++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1;
    repeat (3) @(posedge clock);
    t_count();
    t_two();
    t_pulse();
    t_clear();
    complete_run();
  end
endmodule : tb_top

// ===== hw/qcr_defines.svh
// Purpose: shared constants for the quadrature count read-out block
// Assumes: included by bare name from the half-pulse and read-out design files
// Notes: values are hardware figures, used through the names only
`ifndef QCR_DEFINES_SVH
`define QCR_DEFINES_SVH

`define QCR_FULL_WIDTH 16
`define QCR_BYTE_WIDTH 8
`define QCR_LATCH_RESET 16'h0000
`define QCR_LOW_BYTE_LSB 0
`define QCR_HIGH_BYTE_LSB 8
`define QCR_DIR_LEAD_CYCLES 1

`endif

// ===== hw/qcr_half_pulse.sv
// Purpose: half-cycle pulse from a per-cycle fire request
// Assumes: fire is a level sampled on rising edges
// Notes: pulse is high from the rising edge to the following falling edge
`timescale 1ns/1ps
`include "qcr_defines.svh"

module qcr_half_pulse
  import qcr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // request and pulse
  input wire logic fire,
  output logic pulse
);

  logic rise_tgl_reg;
  logic fall_tgl_reg;

  // toggles, so back-to-back requests still give separate pulses
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rise_tgl_reg <= 1'b0;
    end else if (fire) begin
      rise_tgl_reg <= ~rise_tgl_reg;
    end
  end

  always_ff @(negedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fall_tgl_reg <= 1'b0;
    end else begin
      fall_tgl_reg <= rise_tgl_reg;
    end
  end

  assign pulse = rise_tgl_reg ^ fall_tgl_reg;

endmodule : qcr_half_pulse

// ===== hw/qcr_pkg.sv
// Purpose: types for the quadrature count read-out block
// Assumes: nothing beyond the defines header
// Notes: inhibit sequence states
package qcr_pkg;

  typedef enum logic [1:0] {
    QCR_IDLE = 2'b00,
    QCR_HELD = 2'b01,
    QCR_ARMED = 2'b10
  } qcr_inhibit_t;

endpackage : qcr_pkg

// ===== hw/qcr_readout.sv
// Purpose: position latch, inhibit logic, byte bus and cascade outputs
// Assumes: counter_value, count_event and count_up come from the counter job
// Notes: count_event marks a count one cycle before the counter takes it
`timescale 1ns/1ps
`include "qcr_defines.svh"

module qcr_readout
  import qcr_pkg::*;
#(
  parameter int WIDTH = `QCR_FULL_WIDTH
) (
  // clock and resets
  input wire logic clock,
  input wire logic rstn,
  input wire logic clear_n,
  // from the up/down counter
  input wire logic [WIDTH-1:0] counter_value,
  input wire logic count_event,
  input wire logic count_up,
  // host byte bus
  input wire logic oe_n,
  input wire logic byte_sel,
  output logic [`QCR_BYTE_WIDTH-1:0] byte_bus,
  output logic byte_bus_oe,
  // cascade outputs
  output logic decode_count_pulse,
  output logic carry_borrow_pulse,
  output logic up_down,
  // status
  output logic inhibit
);

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic arst_n;
  logic [WIDTH-1:0] latch_reg;
  logic [`QCR_FULL_WIDTH-1:0] latch_wide;
  qcr_inhibit_t inh_reg;
  qcr_inhibit_t inh_next;
  logic up_down_reg;
  logic dec_pend_reg;
  logic cas_pend_reg;
  logic dec_fire_reg;
  logic cas_fire_reg;
  logic wrap;

  // reset release through two flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // latch and inhibit clear acts without the clock
  assign arst_n = rst_sync_reg & clear_n;

  // position latch
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      latch_reg <= WIDTH'(`QCR_LATCH_RESET);
    end else if (!inhibit) begin
      latch_reg <= counter_value;
    end
  end

  // narrow variant pads the high byte with zeros
  always_comb begin
    latch_wide = '0;
    latch_wide[WIDTH-1:0] = latch_reg;
  end

  // inhibit sequence, decided on falling edges
  always_comb begin
    inh_next = inh_reg;
    unique case (inh_reg)
      QCR_IDLE: begin
        if (!oe_n && !byte_sel) begin
          inh_next = QCR_HELD;
        end
      end
      QCR_HELD: begin
        // enable may rise between bytes; stay held
        if (!oe_n && byte_sel) begin
          inh_next = QCR_ARMED;
        end
      end
      QCR_ARMED: begin
        if (oe_n) begin
          inh_next = QCR_IDLE;
        end
      end
      default: begin
        inh_next = QCR_IDLE;
      end
    endcase
  end

  // sampling needs enable and select steady around the fall
  always_ff @(negedge clock or negedge arst_n) begin
    if (!arst_n) begin
      inh_reg <= QCR_IDLE;
    end else begin
      inh_reg <= inh_next;
    end
  end

  assign inhibit = (inh_reg != QCR_IDLE);

  // byte bus: select low gives the high byte
  always_comb begin
    if (byte_sel) begin
      byte_bus = latch_wide[`QCR_LOW_BYTE_LSB +: `QCR_BYTE_WIDTH];
    end else begin
      byte_bus = latch_wide[`QCR_HIGH_BYTE_LSB +: `QCR_BYTE_WIDTH];
    end
  end

  assign byte_bus_oe = ~oe_n;

  // wrap seen on the value before the counter takes the count
  assign wrap = count_up ? (&counter_value) : ~(|counter_value);

  // direction leads the pulse by a cycle; inhibit never looks in here
  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      up_down_reg <= 1'b0;
      dec_pend_reg <= 1'b0;
      cas_pend_reg <= 1'b0;
      dec_fire_reg <= 1'b0;
      cas_fire_reg <= 1'b0;
    end else begin
      if (count_event) begin
        up_down_reg <= count_up;
      end
      dec_pend_reg <= count_event;
      cas_pend_reg <= count_event & wrap;
      dec_fire_reg <= dec_pend_reg;
      cas_fire_reg <= cas_pend_reg;
    end
  end

  assign up_down = up_down_reg;

  qcr_half_pulse u_dec_pulse (
    .clock(clock),
    .arst_n(rst_sync_reg),
    .fire(dec_pend_reg),
    .pulse(decode_count_pulse)
  );

  qcr_half_pulse u_cas_pulse (
    .clock(clock),
    .arst_n(rst_sync_reg),
    .fire(cas_pend_reg),
    .pulse(carry_borrow_pulse)
  );

  // checks
  a_latch_loads: assert property (
    @(posedge clock) disable iff (!arst_n)
    !inhibit |=> (latch_reg == $past(counter_value))
  ) else $error("latch did not take counter value");

  a_latch_frozen: assert property (
    @(posedge clock) disable iff (!arst_n)
    inhibit |=> $stable(latch_reg)
  ) else $error("latch moved while inhibited");

  a_clear_latch: assert property (
    @(posedge clock)
    (!clear_n && rst_sync_reg) |-> (latch_reg == '0 && !inhibit)
  ) else $error("clear left latch or inhibit set");

  a_high_byte_out: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!oe_n && !byte_sel) |-> (byte_bus_oe && byte_bus == latch_wide[15:8])
  ) else $error("high byte not driven");

  a_low_byte_out: assert property (
    @(posedge clock) disable iff (!arst_n)
    byte_sel |-> (byte_bus == latch_reg[7:0] && byte_bus_oe == !oe_n)
  ) else $error("low byte not driven");

  a_inhibit_set: assert property (
    @(negedge clock) disable iff (!arst_n)
    (inh_reg == QCR_IDLE && !byte_sel && !oe_n) |=> inhibit
  ) else $error("inhibit not set by high byte read");

  a_release_armed: assert property (
    @(negedge clock) disable iff (!arst_n)
    (inh_reg == QCR_HELD && byte_sel && !oe_n) |=> (inh_reg == QCR_ARMED && inhibit)
  ) else $error("release not armed by low byte read");

  a_release_done: assert property (
    @(negedge clock) disable iff (!arst_n)
    (inh_reg == QCR_ARMED && oe_n) |=> !inhibit
  ) else $error("inhibit not cleared after read");

  a_single_byte: assert property (
    @(negedge clock) disable iff (!arst_n)
    (inh_reg == QCR_IDLE && byte_sel) |=> !inhibit
  ) else $error("single byte read set inhibit");

  a_decode_half: assert property (
    @(negedge clock) disable iff (!rst_sync_reg)
    decode_count_pulse == dec_fire_reg
  ) else $error("decode pulse wrong in first half cycle");

  a_cascade_half: assert property (
    @(negedge clock) disable iff (!rst_sync_reg)
    carry_borrow_pulse == cas_fire_reg
  ) else $error("cascade pulse wrong in first half cycle");

  a_pulse_free: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    count_event |-> ##2 dec_fire_reg
  ) else $error("decode pulse missing two cycles after count");

  a_dir_steady: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    (dec_pend_reg && !count_event) |=> $stable(up_down_reg)
  ) else $error("direction moved at pulse rise");

  a_narrow_high: assert property (
    @(posedge clock) disable iff (!arst_n)
    !byte_sel |-> ((byte_bus >> (WIDTH - `QCR_BYTE_WIDTH)) == '0)
  ) else $error("unused high byte bits not zero");

  a_bus_drive: assert property (
    @(posedge clock)
    !oe_n |-> byte_bus_oe
  ) else $error("bus not driven while enabled");

  a_bus_float: assert property (
    @(posedge clock)
    oe_n |-> !byte_bus_oe
  ) else $error("bus driven while disabled");

  a_held_stay: assert property (
    @(negedge clock) disable iff (!arst_n)
    (inh_reg == QCR_HELD && !oe_n && !byte_sel) |=> (inh_reg == QCR_HELD)
  ) else $error("held state left during high byte read");

  a_held_gap: assert property (
    @(negedge clock) disable iff (!arst_n)
    (inh_reg == QCR_HELD && oe_n) |=> (inh_reg == QCR_HELD)
  ) else $error("inhibit lost between two short enables");

  a_armed_stay: assert property (
    @(negedge clock) disable iff (!arst_n)
    (inh_reg == QCR_ARMED && !oe_n) |=> (inh_reg == QCR_ARMED)
  ) else $error("release finished while still enabled");

  a_inhibit_rise: assert property (
    @(negedge clock) disable iff (!arst_n)
    $rose(inhibit) |-> ($past(oe_n) == 1'b0 && $past(byte_sel) == 1'b0)
  ) else $error("inhibit set without high byte read");

  a_clear_idle: assert property (
    @(negedge clock)
    !clear_n |-> (inh_reg == QCR_IDLE)
  ) else $error("clear left inhibit sequence running");

  a_dir_lead: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    dec_pend_reg |-> (up_down == $past(count_up))
  ) else $error("direction not ready before pulse");

  a_decode_ends: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    !decode_count_pulse
  ) else $error("decode pulse longer than half a cycle");

  a_cascade_ends: assert property (
    @(posedge clock) disable iff (!rst_sync_reg)
    !carry_borrow_pulse
  ) else $error("cascade pulse longer than half a cycle");

endmodule : qcr_readout
